/* File: include/cpurf_pkg.sv */
// Constants and carriers for the CPU register set and flags.
// Assumes a single core clock; software reaches it over classic Wishbone.
//
// Functional notes
// RULE_01: Thirteen registers; seven in two banks.
// RULE_02: Data registers 16 bits; first two byte-split.
// RULE_03: Third pairs over first, fourth over second.
// RULE_04: Address registers 16 bits; second is upper.
// RULE_05: Frame and static base 16 bits each.
// RULE_06: Vector table base is 20 bits.
// RULE_07: Program counter 20 bits, next instruction.
// RULE_08: Two 16-bit stack pointers, flag selects.
// RULE_09: Flag register 11 bits of processor state.
// RULE_10: Carry flag takes ALU carry or shift-out.
// RULE_11: Software keeps debug flag at zero.
// RULE_12: Zero flag set on zero result.
// RULE_13: Sign flag set on negative result.
// RULE_14: Bank flag selects bank zero or one.
// RULE_15: Overflow flag set on overflow.
// RULE_16: Interrupt enable flag gates maskable interrupts.
// RULE_17: Any interrupt acknowledge clears interrupt enable.
// RULE_18: Stack flag zero picks interrupt stack.
// RULE_19: Hardware acknowledge or low software interrupt clears stack flag.
// RULE_20: Three-bit priority; accept only higher requests.
// RULE_21: Updates take effect on the completing clock edge.
package cpurf_pkg;
    // ----------------------------------------
    // Register selectors and bus offsets
    // ----------------------------------------
    localparam logic [3:0] SEL_DATA0 = 4'h0;
    localparam logic [3:0] SEL_DATA1 = 4'h1;
    localparam logic [3:0] SEL_DATA2 = 4'h2;
    localparam logic [3:0] SEL_DATA3 = 4'h3;
    localparam logic [3:0] SEL_ADDR0 = 4'h4;
    localparam logic [3:0] SEL_ADDR1 = 4'h5;
    localparam logic [3:0] SEL_FRAME = 4'h6;
    localparam logic [3:0] SEL_VTB = 4'h7;
    localparam logic [3:0] SEL_PC = 4'h8;
    localparam logic [3:0] SEL_USP = 4'h9;
    localparam logic [3:0] SEL_ISP = 4'ha;
    localparam logic [3:0] SEL_SB = 4'hb;
    localparam logic [3:0] SEL_FLG = 4'hc;
    localparam logic [3:0] SEL_SP = 4'hd;
    localparam int NUM_REGS = 13;
    localparam int ADDR_LSB = 2;
    // ----------------------------------------
    // Flag field positions
    // ----------------------------------------
    localparam int FLG_C = 0;
    localparam int FLG_D = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_S = 3;
    localparam int FLG_B = 4;
    localparam int FLG_O = 5;
    localparam int FLG_I = 6;
    localparam int FLG_U = 7;
    localparam int FLG_IPL_LSB = 8;
    localparam int FLG_W = 11;
    localparam int IPL_W = 3;
    // ----------------------------------------
    // Reset values and low software interrupt limit
    // ----------------------------------------
    localparam logic [15:0] RST_16 = 16'h0000;
    localparam logic [19:0] RST_20 = 20'h00000;
    localparam logic [10:0] RST_FLG = 11'h000;
    localparam logic [5:0] SWI_LOW_LAST = 6'h1f;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic overflow;
    } cpurf_alu_flags_t;
    typedef struct packed {
        logic [2:0] level;
        logic hw;
        logic swi;
        logic [5:0] swi_num;
    } cpurf_irq_req_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cpurf_wb_req_t;
endpackage : cpurf_pkg

/* File: core/cpurf_core.sv */
// CPU register set: two banks, pointers, flags, interrupt accept logic.
// Assumes the datapath sends one write per completing instruction and a
// single-cycle acknowledge; Wishbone writes yield to datapath writes.
`timescale 1ns/1ns
module cpurf_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Datapath write port
    input wire logic dp_we_i,
    input wire logic [3:0] dp_sel_i,
    input wire logic [1:0] dp_mode_i,
    input wire logic [31:0] dp_wdata_i,
    input wire logic dp_flag_we_i,
    input wire cpurf_pkg::cpurf_alu_flags_t dp_flags_i,
    input wire logic dp_pc_we_i,
    input wire logic [19:0] dp_pc_i,
    // Datapath read port
    input wire logic [3:0] dp_rsel_i,
    output logic [31:0] dp_rdata_o,
    output logic [15:0] active_sp_o,
    output logic [19:0] pc_o,
    output logic [10:0] flags_o,
    // Interrupt side
    input wire logic irq_req_i,
    input wire cpurf_pkg::cpurf_irq_req_t irq_i,
    input wire logic irq_ack_i,
    output logic irq_accept_o,
    // Wishbone slave
    input wire cpurf_pkg::cpurf_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0] bank_data_reg [2][4]; // see RULE_01
    logic [15:0] bank_addr_reg [2][2];
    logic [15:0] bank_fb_reg [2];
    logic [19:0] vtb_reg; // see RULE_06
    logic [19:0] pc_reg; // see RULE_07
    logic [15:0] usp_reg;
    logic [15:0] isp_reg; // see RULE_08
    logic [15:0] sb_reg; // see RULE_05
    logic [10:0] flg_reg; // see RULE_09
    logic bank;
    logic wb_hit;
    logic wb_wr;
    logic [3:0] wb_rsel;
    logic wr_en;
    logic [3:0] wr_sel;
    logic [1:0] wr_mode;
    logic [31:0] wr_data;
    logic irq_ok;

    assign bank = flg_reg[cpurf_pkg::FLG_B]; // see RULE_14
    assign wb_rsel = wb_i.adr[cpurf_pkg::ADDR_LSB +: 4];
    assign wb_hit = wb_i.cyc && wb_i.stb && !wb_ack_o;
    assign wb_wr = wb_hit && wb_i.we && !dp_we_i;
    // Datapath owns the port; a colliding bus write waits one cycle
    assign wr_en = dp_we_i || wb_wr;
    assign wr_sel = dp_we_i ? dp_sel_i : wb_rsel;
    assign wr_mode = dp_we_i ? dp_mode_i : 2'h0;
    assign wr_data = dp_we_i ? dp_wdata_i : wb_i.dat;

    // Mode 0 word, 1 low byte, 2 high byte, 3 wide pair
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [1:0] m,
                                          input logic [15:0] d, input logic split);
        merge = d;
        if (split && m == 2'h1) begin
            merge = {old[15:8], d[7:0]};
        end else if (split && m == 2'h2) begin
            merge = {d[7:0], old[7:0]};
        end
    endfunction : merge

    function automatic logic [31:0] rd(input logic [3:0] s);
        rd = 32'h00000000;
        unique case (s)
            cpurf_pkg::SEL_DATA0: rd = {bank_data_reg[bank][2], bank_data_reg[bank][0]}; // see RULE_03
            cpurf_pkg::SEL_DATA1: rd = {bank_data_reg[bank][3], bank_data_reg[bank][1]};
            cpurf_pkg::SEL_DATA2: rd = {16'h0000, bank_data_reg[bank][2]};
            cpurf_pkg::SEL_DATA3: rd = {16'h0000, bank_data_reg[bank][3]};
            cpurf_pkg::SEL_ADDR0: rd = {bank_addr_reg[bank][1], bank_addr_reg[bank][0]}; // see RULE_04
            cpurf_pkg::SEL_ADDR1: rd = {16'h0000, bank_addr_reg[bank][1]};
            cpurf_pkg::SEL_FRAME: rd = {16'h0000, bank_fb_reg[bank]};
            cpurf_pkg::SEL_VTB: rd = {12'h000, vtb_reg};
            cpurf_pkg::SEL_PC: rd = {12'h000, pc_reg};
            cpurf_pkg::SEL_USP: rd = {16'h0000, usp_reg};
            cpurf_pkg::SEL_ISP: rd = {16'h0000, isp_reg};
            cpurf_pkg::SEL_SB: rd = {16'h0000, sb_reg};
            cpurf_pkg::SEL_FLG: rd = {21'h000000, flg_reg};
            cpurf_pkg::SEL_SP: rd = {16'h0000, flg_reg[cpurf_pkg::FLG_U] ? usp_reg : isp_reg};
            default: rd = 32'h00000000;
        endcase
    endfunction : rd

    // ----------------------------------------
    // Banked registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int b = 0; b < 2; b++) begin
                for (int k = 0; k < 4; k++) begin
                    bank_data_reg[b][k] <= cpurf_pkg::RST_16;
                end
                bank_addr_reg[b][0] <= cpurf_pkg::RST_16;
                bank_addr_reg[b][1] <= cpurf_pkg::RST_16;
                bank_fb_reg[b] <= cpurf_pkg::RST_16;
            end
        end else if (wr_en) begin // see RULE_21
            // Only the bank chosen now is written
            if (wr_sel <= cpurf_pkg::SEL_DATA3) begin
                bank_data_reg[bank][wr_sel[1:0]] <= merge(bank_data_reg[bank][wr_sel[1:0]], wr_mode,
                                                          wr_data[15:0], !wr_sel[1]); // see RULE_02
                if (wr_mode == 2'h3 && !wr_sel[1]) begin
                    bank_data_reg[bank][{1'b1, wr_sel[0]}] <= wr_data[31:16]; // see RULE_03
                end
            end else if (wr_sel == cpurf_pkg::SEL_ADDR0) begin
                bank_addr_reg[bank][0] <= wr_data[15:0];
                if (wr_mode == 2'h3) begin
                    bank_addr_reg[bank][1] <= wr_data[31:16]; // see RULE_04
                end
            end else if (wr_sel == cpurf_pkg::SEL_ADDR1) begin
                bank_addr_reg[bank][1] <= wr_data[15:0];
            end else if (wr_sel == cpurf_pkg::SEL_FRAME) begin
                bank_fb_reg[bank] <= wr_data[15:0]; // see RULE_05
            end
        end
    end

    // ----------------------------------------
    // Common registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vtb_reg <= cpurf_pkg::RST_20;
            usp_reg <= cpurf_pkg::RST_16;
            isp_reg <= cpurf_pkg::RST_16;
            sb_reg <= cpurf_pkg::RST_16;
        end else if (wr_en) begin
            if (wr_sel == cpurf_pkg::SEL_VTB) begin
                vtb_reg <= wr_data[19:0]; // see RULE_06
            end
            if (wr_sel == cpurf_pkg::SEL_USP ||
                (wr_sel == cpurf_pkg::SEL_SP && flg_reg[cpurf_pkg::FLG_U])) begin
                usp_reg <= wr_data[15:0]; // see RULE_08
            end
            if (wr_sel == cpurf_pkg::SEL_ISP ||
                (wr_sel == cpurf_pkg::SEL_SP && !flg_reg[cpurf_pkg::FLG_U])) begin
                isp_reg <= wr_data[15:0]; // see RULE_18
            end
            if (wr_sel == cpurf_pkg::SEL_SB) begin
                sb_reg <= wr_data[15:0];
            end
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= cpurf_pkg::RST_20;
        end else if (dp_pc_we_i) begin
            pc_reg <= dp_pc_i; // see RULE_07
        end else if (wr_en && wr_sel == cpurf_pkg::SEL_PC) begin
            pc_reg <= wr_data[19:0];
        end
    end

    // ----------------------------------------
    // Flag register
    // ----------------------------------------
    // Acknowledge clears win over a same-cycle write of the flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flg_reg <= cpurf_pkg::RST_FLG;
        end else begin
            if (wr_en && wr_sel == cpurf_pkg::SEL_FLG) begin
                flg_reg <= wr_data[10:0]; // see RULE_09
            end
            if (dp_flag_we_i) begin
                flg_reg[cpurf_pkg::FLG_C] <= dp_flags_i.carry; // see RULE_10
                flg_reg[cpurf_pkg::FLG_Z] <= dp_flags_i.zero; // see RULE_12
                flg_reg[cpurf_pkg::FLG_S] <= dp_flags_i.sign; // see RULE_13
                flg_reg[cpurf_pkg::FLG_O] <= dp_flags_i.overflow; // see RULE_15
            end
            if (irq_ack_i) begin
                flg_reg[cpurf_pkg::FLG_I] <= 1'b0; // see RULE_17
                if (irq_i.hw || (irq_i.swi && irq_i.swi_num <= cpurf_pkg::SWI_LOW_LAST)) begin
                    flg_reg[cpurf_pkg::FLG_U] <= 1'b0; // see RULE_19
                end
            end
        end
    end

    // ----------------------------------------
    // Interrupt acceptance
    // ----------------------------------------
    assign irq_ok = irq_req_i && flg_reg[cpurf_pkg::FLG_I] &&
                    (irq_i.level > flg_reg[cpurf_pkg::FLG_IPL_LSB +: cpurf_pkg::IPL_W]);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_accept_o <= 1'b0;
        end else begin
            irq_accept_o <= irq_ok && !irq_ack_i; // see RULE_16 see RULE_20
        end
    end

    // ----------------------------------------
    // Read ports
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dp_rdata_o <= 32'h00000000;
        end else begin
            dp_rdata_o <= rd(dp_rsel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_sp_o <= cpurf_pkg::RST_16;
        end else begin
            active_sp_o <= flg_reg[cpurf_pkg::FLG_U] ? usp_reg : isp_reg; // see RULE_18
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= cpurf_pkg::RST_20;
        end else begin
            pc_o <= pc_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= cpurf_pkg::RST_FLG;
        end else begin
            flags_o <= flg_reg;
        end
    end

    // Bus write stalls a cycle behind a datapath write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit && !(wb_i.we && dp_we_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= (wb_hit && !wb_i.we) ? rd(wb_rsel) : 32'h00000000;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    stack_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_19
        irq_ack_i && irq_i.hw
        |=> !flg_reg[cpurf_pkg::FLG_U])
        else $error("stack flag not cleared on hw ack");

    swi_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_19
        irq_ack_i && irq_i.swi && irq_i.swi_num <= cpurf_pkg::SWI_LOW_LAST
        |=> !flg_reg[cpurf_pkg::FLG_U])
        else $error("stack flag not cleared on low swi");

    swi_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_19
        !irq_i.hw && irq_i.swi_num > cpurf_pkg::SWI_LOW_LAST && !(wr_en && wr_sel == cpurf_pkg::SEL_FLG)
        |=> flg_reg[cpurf_pkg::FLG_U] == $past(flg_reg[cpurf_pkg::FLG_U]))
        else $error("stack flag lost on high swi");

    ienable_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_17
        irq_ack_i
        |=> ##1 !flags_o[cpurf_pkg::FLG_I])
        else $error("enable flag not cleared on ack");

    accept_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_17
        irq_ack_i
        |=> !irq_accept_o)
        else $error("accept held through ack");

    masked_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_16
        irq_accept_o
        |-> $past(flg_reg[cpurf_pkg::FLG_I]))
        else $error("accept while interrupts disabled");

    prio_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_20
        irq_accept_o
        |-> $past(irq_i.level) > $past(flg_reg[cpurf_pkg::FLG_IPL_LSB +: cpurf_pkg::IPL_W]))
        else $error("accept at low priority");

    accept_rise_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_20
        irq_req_i && !irq_ack_i && flg_reg[cpurf_pkg::FLG_I]
        && irq_i.level > flg_reg[cpurf_pkg::FLG_IPL_LSB +: cpurf_pkg::IPL_W] |=> irq_accept_o)
        else $error("higher request not accepted");

    zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_12
        dp_flag_we_i && !irq_ack_i
        |=> flg_reg[cpurf_pkg::FLG_Z] == $past(dp_flags_i.zero))
        else $error("zero flag not taken");

    carry_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_10
        dp_flag_we_i
        |=> flg_reg[cpurf_pkg::FLG_C] == $past(dp_flags_i.carry))
        else $error("carry flag not taken");

    sign_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_13
        dp_flag_we_i
        |=> flg_reg[cpurf_pkg::FLG_S] == $past(dp_flags_i.sign))
        else $error("sign flag not taken");

    ovf_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_15
        dp_flag_we_i
        |=> flg_reg[cpurf_pkg::FLG_O] == $past(dp_flags_i.overflow))
        else $error("overflow flag not taken");

    flags_view_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_09
        1'b1
        |=> flags_o == $past(flg_reg))
        else $error("flag output out of step");

    active_sp_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_18
        1'b1
        |=> active_sp_o == ($past(flg_reg[cpurf_pkg::FLG_U]) ? $past(usp_reg) : $past(isp_reg)))
        else $error("wrong stack pointer");

    pc_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_07
        dp_pc_we_i
        |=> ##1 pc_o == $past(dp_pc_i, 2))
        else $error("pc not loaded");

    pc_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_21
        !dp_pc_we_i && !(wr_en && wr_sel == cpurf_pkg::SEL_PC)
        |=> $stable(pc_reg))
        else $error("pc moved without a write");

    pair_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_03
        dp_we_i && dp_sel_i == cpurf_pkg::SEL_DATA0 && dp_mode_i == 2'h3
        |=> bank_data_reg[$past(bank)][2] == $past(dp_wdata_i[31:16]))
        else $error("wide pair upper half lost");

    byte_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_02
        dp_we_i && dp_sel_i == cpurf_pkg::SEL_DATA1 && dp_mode_i == 2'h1
        |=> bank_data_reg[$past(bank)][1][15:8] == $past(bank_data_reg[bank][1][15:8]))
        else $error("low byte write touched high byte");

    bank_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_14
        dp_rsel_i == cpurf_pkg::SEL_FRAME
        |=> dp_rdata_o == {16'h0000, $past(bank_fb_reg[bank])})
        else $error("frame read from wrong bank");

    wb_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_05
        wb_wr && wb_rsel == cpurf_pkg::SEL_SB
        |=> sb_reg == $past(wb_i.dat[15:0]))
        else $error("bus write to static base lost");

    wb_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_i.cyc && wb_i.stb && !wb_i.we && !wb_ack_o
        |=> wb_ack_o)
        else $error("bus read not answered");

    wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o
        |=> !wb_ack_o)
        else $error("ack held two cycles");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    hw_irq_c: cover property (@(posedge clk_i) disable iff (rst_i) irq_ack_i && irq_i.hw);
    swi_ack_c: cover property (@(posedge clk_i) disable iff (rst_i) irq_ack_i && irq_i.swi);
    accept_c: cover property (@(posedge clk_i) disable iff (rst_i) irq_accept_o);
    bank_swap_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(bank));
    wb_read_c: cover property (@(posedge clk_i) disable iff (rst_i) wb_ack_o && !wb_i.we);
endmodule : cpurf_core

/* File: tb/cpurf_dp_model.sv */
// Model of the execution datapath and interrupt acknowledge logic.
// Assumes its tasks are entered just after a rising edge of clk_i.
`timescale 1ns/1ns
module cpurf_dp_model (
    // Clock
    input wire logic clk_i,
    // Datapath writes
    output logic dp_we_o,
    output logic [3:0] dp_sel_o,
    output logic [1:0] dp_mode_o,
    output logic [31:0] dp_wdata_o,
    output logic dp_flag_we_o,
    output cpurf_pkg::cpurf_alu_flags_t dp_flags_o,
    output logic dp_pc_we_o,
    output logic [19:0] dp_pc_o,
    // Interrupt side
    output logic irq_req_o,
    output cpurf_pkg::cpurf_irq_req_t irq_o,
    output logic irq_ack_o
);
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    initial begin
        {dp_we_o, dp_sel_o, dp_mode_o, dp_wdata_o, dp_flag_we_o, dp_flags_o} = '0;
        {dp_pc_we_o, dp_pc_o, irq_req_o, irq_o, irq_ack_o} = '0;
    end
    // Released data is inverted so a stale value never passes
    task automatic wr(input logic [3:0] s, input logic [1:0] m, input logic [31:0] d);
        dp_sel_o <= s;
        dp_mode_o <= m;
        dp_wdata_o <= d;
        dp_we_o <= 1'b1;
        @(posedge clk_i);
        dp_we_o <= 1'b0;
        dp_wdata_o <= ~d;
        @(posedge clk_i);
    endtask : wr
    // Only the four ALU flags travel here, debug stays clear
    task automatic fl(input cpurf_pkg::cpurf_alu_flags_t f);
        dp_flags_o <= f;
        dp_flag_we_o <= 1'b1;
        @(posedge clk_i);
        dp_flag_we_o <= 1'b0;
        dp_flags_o <= ~f;
        @(posedge clk_i);
    endtask : fl
    task automatic pc(input logic [19:0] p);
        dp_pc_o <= p;
        dp_pc_we_o <= 1'b1;
        @(posedge clk_i);
        dp_pc_we_o <= 1'b0;
        dp_pc_o <= ~p;
        @(posedge clk_i);
    endtask : pc
    task automatic req(input cpurf_pkg::cpurf_irq_req_t r);
        irq_o <= r;
        irq_req_o <= 1'b1;
    endtask : req
    // One-cycle acknowledge; the request is withdrawn with it
    task automatic ack();
        irq_ack_o <= 1'b1;
        @(posedge clk_i);
        irq_ack_o <= 1'b0;
        irq_req_o <= 1'b0;
        @(posedge clk_i);
    endtask : ack
endmodule : cpurf_dp_model

/* File: tb/tb_top.sv */
// Self-checking bench for the CPU register set and flags.
// Assumes cpurf_pkg, cpurf_core and cpurf_dp_model are compiled first.
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // Wiring
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] dp_rsel_i = 4'h0;
    cpurf_pkg::cpurf_wb_req_t wb_i = '0;
    logic dp_we_i, dp_flag_we_i, dp_pc_we_i, irq_req_i, irq_ack_i, irq_accept_o, wb_ack_o;
    logic [3:0] dp_sel_i;
    logic [1:0] dp_mode_i;
    logic [31:0] dp_wdata_i, dp_rdata_o, wb_dat_o, q;
    logic [19:0] dp_pc_i, pc_o;
    logic [15:0] active_sp_o;
    logic [10:0] flags_o;
    cpurf_pkg::cpurf_alu_flags_t dp_flags_i;
    cpurf_pkg::cpurf_irq_req_t irq_i;
    int n_mismatch = 0;
    int checks = 0;
    // Address, write data, expected read back
    logic [69:0] rows [10] = '{
        {6'h08, 32'hffff1234, 32'h1234},
        {6'h0c, 32'h00018001, 32'h8001},
        {6'h14, 32'h12345678, 32'h5678},
        {6'h18, 32'habcdef01, 32'hef01},
        {6'h1c, 32'hffffffff, 32'hfffff},
        {6'h20, 32'h00123456, 32'h23456},
        {6'h24, 32'h0000beef, 32'hbeef},
        {6'h28, 32'h00001357, 32'h1357},
        {6'h2c, 32'h77772468, 32'h2468},
        {6'h38, 32'hdeadbeef, 32'h0}};
    always #2 clk_i = ~clk_i;
    cpurf_dp_model i_model (.clk_i(clk_i), .dp_we_o(dp_we_i), .dp_sel_o(dp_sel_i), .dp_mode_o(dp_mode_i),
        .dp_wdata_o(dp_wdata_i), .dp_flag_we_o(dp_flag_we_i), .dp_flags_o(dp_flags_i), .dp_pc_we_o(dp_pc_we_i),
        .dp_pc_o(dp_pc_i), .irq_req_o(irq_req_i), .irq_o(irq_i), .irq_ack_o(irq_ack_i));
    cpurf_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .dp_we_i(dp_we_i), .dp_sel_i(dp_sel_i),
        .dp_mode_i(dp_mode_i), .dp_wdata_i(dp_wdata_i), .dp_flag_we_i(dp_flag_we_i), .dp_flags_i(dp_flags_i),
        .dp_pc_we_i(dp_pc_we_i), .dp_pc_i(dp_pc_i), .dp_rsel_i(dp_rsel_i), .dp_rdata_o(dp_rdata_o),
        .active_sp_o(active_sp_o), .pc_o(pc_o), .flags_o(flags_o), .irq_req_i(irq_req_i), .irq_i(irq_i),
        .irq_ack_i(irq_ack_i), .irq_accept_o(irq_accept_o), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // No local limit: only the watchdog ends a hung wait
    task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
        wb_i <= {1'b1, 1'b1, we, a, 4'hf, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_i <= '0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd_dp(input logic [3:0] s);
        dp_rsel_i <= s;
        repeat (2) @(posedge clk_i);
        q = dp_rdata_o;
    endtask : rd_dp
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask : settle
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    // Whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 6'h30, 32'h0);
        chk(q, 32'h0);
        foreach (rows[i]) begin
            wb(1'b1, rows[i][69:64], rows[i][63:32]);
            wb(1'b0, rows[i][69:64], 32'h0);
            chk(q, rows[i][31:0]);
        end
        done("table");
        i_model.wr(cpurf_pkg::SEL_DATA0, 2'd3, 32'h11112222);
        i_model.wr(cpurf_pkg::SEL_DATA0, 2'd1, 32'h000000ab);
        i_model.wr(cpurf_pkg::SEL_DATA0, 2'd2, 32'h000000cd);
        rd_dp(cpurf_pkg::SEL_DATA0);
        chk(q, 32'h1111cdab);
        i_model.wr(cpurf_pkg::SEL_DATA1, 2'd1, 32'h00000055);
        rd_dp(cpurf_pkg::SEL_DATA1);
        chk(q, 32'h80010055);
        i_model.wr(cpurf_pkg::SEL_ADDR0, 2'd3, 32'h99998888);
        rd_dp(cpurf_pkg::SEL_ADDR0);
        chk(q, 32'h99998888);
        rd_dp(cpurf_pkg::SEL_FRAME);
        chk(q, 32'h0000ef01);
        i_model.pc(20'habcde);
        settle();
        chk({12'h0, pc_o}, 32'habcde);
        done("datapath");
        wb(1'b1, 6'h30, 32'h10);
        wb(1'b0, 6'h08, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 6'h08, 32'h4444);
        wb(1'b1, 6'h30, 32'h0);
        wb(1'b0, 6'h08, 32'h0);
        chk(q, 32'h1111);
        done("banks");
        i_model.fl(4'b1011);
        settle();
        chk({21'h0, flags_o}, 32'h29);
        i_model.fl(4'b0100);
        settle();
        chk({21'h0, flags_o}, 32'h04);
        wb(1'b1, 6'h30, 32'h80);
        settle();
        chk({16'h0, active_sp_o}, 32'hbeef);
        wb(1'b1, 6'h30, 32'h0);
        settle();
        chk({16'h0, active_sp_o}, 32'h1357);
        done("flags");
        wb(1'b1, 6'h30, 32'h3c0);
        i_model.req({3'd3, 1'b1, 1'b0, 6'h00});
        settle();
        chk({31'h0, irq_accept_o}, 32'h0);
        i_model.req({3'd4, 1'b1, 1'b0, 6'h00});
        settle();
        chk({31'h0, irq_accept_o}, 32'h1);
        i_model.ack();
        settle();
        chk({21'h0, flags_o}, 32'h300);
        i_model.req({3'd7, 1'b1, 1'b0, 6'h00});
        settle();
        chk({31'h0, irq_accept_o}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, 6'h30, 32'h3c0);
            i_model.req({3'd7, 1'b0, 1'b1, k ? 6'h1f : 6'h20});
            i_model.ack();
            settle();
            chk({21'h0, flags_o}, k ? 32'h300 : 32'h380);
        end
        done("interrupts");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 6'h08, 32'h0);
        chk(q, 32'h0);
        done("second reset");
        stop_test();
    end
endmodule : tb_top
